// [pkg/sre_pkg.sv]
// constants, types and states of the serial eeprom read engine
// assumes one 40 MHz clock; bus lines sampled as synchronous inputs
// Operation
// - read header equals write header but direction bit is 1.
// - support current-address, located and multi-byte read forms.
// - word counter holds last accessed location plus one.
// - counter survives between transactions, no reload at start or stop.
// - read increment wraps whole array from top byte to zero.
// - after acked read header, shift out counter's byte msb first.
// - device acks second header and sends byte at loaded location.
// - multi-byte read may start from either read form.
// - counter advances after each byte sent; master ack sends next byte at once.
// - top of memory does not stop multi-byte read; counter wraps.
// - nack then stop ends multi-byte read; device stops driving.
// - bytes are eight bits; device acks each received byte low.
// - strap bits must match header; mismatch gives no ack, idle.
// - stop after a read returns device to idle.
package sre_pkg;
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 8;
   localparam int PAGE_W = 7;
   localparam logic [3:0] BITS_FULL = 4'h8;
   localparam logic [4:0] DEV_PREFIX = 5'h14;
   localparam real MCLK_NS = 25.0;

   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } sre_bus_ev_t;

   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_DEV = 11'h002,
      ST_DACK = 11'h004,
      ST_ADRH = 11'h008,
      ST_AACKH = 11'h010,
      ST_ADRL = 11'h020,
      ST_AACKL = 11'h040,
      ST_WDAT = 11'h080,
      ST_WACK = 11'h100,
      ST_RDAT = 11'h200,
      ST_RACK = 11'h400
   } sre_state_t;

   localparam sre_state_t ST_WAIT = ST_IDLE;
endpackage

// [core/sre_bus_cond.sv]
// bus condition detector: serial clock edges, start and stop
// assumes scl and sda already synchronous to mclk_in
`timescale 1ns/100ps
module sre_bus_cond (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output sre_pkg::sre_bus_ev_t ev_out
);
   import sre_pkg::*;

   logic scl_ff;
   logic sda_ff;
   logic nxt_scl;
   logic nxt_sda;

   // ==========================================
   // previous line levels
   always_comb begin
      nxt_scl = scl_in;
      nxt_sda = sda_in;
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         scl_ff <= nxt_scl;
         sda_ff <= nxt_sda;
      end
   end

   // ==========================================
   // edge and condition decode
   always_comb begin
      ev_out.scl_rise = scl_in & ~scl_ff;
      ev_out.scl_fall = ~scl_in & scl_ff;
      ev_out.start = scl_in & scl_ff & sda_ff & ~sda_in;
      ev_out.stop = scl_in & scl_ff & ~sda_ff & sda_in;
   end
endmodule // sre_bus_cond

// [core/sre_read_engine.sv]
// two-wire eeprom target: header decode, address load, reads
// assumes array read data valid one clock after mem_addr_out changes
`timescale 1ns/100ps
module sre_read_engine (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic strap_select_hi_in,
   input wire logic strap_select_lo_in,
   output logic [sre_pkg::ADDR_W-1:0] mem_addr_out,
   input wire logic [sre_pkg::BYTE_W-1:0] mem_data_in,
   output logic [sre_pkg::BYTE_W-1:0] wr_data_out,
   output logic wr_strobe_out
);
   import sre_pkg::*;

   sre_bus_ev_t ev;
   sre_state_t state_ff, nxt_state;
   logic [3:0] bits_ff, nxt_bits;
   logic [BYTE_W-1:0] shift_ff, nxt_shift;
   logic [BYTE_W-1:0] hi_ff, nxt_hi;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [BYTE_W-1:0] wdat_ff, nxt_wdat;
   logic oe_ff, nxt_oe;
   logic rw_ff, nxt_rw;
   logic stb_ff, nxt_stb;
   logic hdr_ok;

   // counter step: whole array, or inside the page for writes
   function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a,
                                                    input logic in_page);
      logic [ADDR_W-1:0] n;
      n = a + 16'h0001;
      if (in_page) begin
         n = {a[ADDR_W-1:PAGE_W], n[PAGE_W-1:0]};
      end
      return n;
   endfunction

   sre_bus_cond u_cond (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .ev_out(ev)
   );

   assign hdr_ok = (shift_ff[7:3] == DEV_PREFIX) &&
                   (shift_ff[2] == strap_select_hi_in) &&
                   (shift_ff[1] == strap_select_lo_in);

   // ==========================================
   // protocol next state
   always_comb begin
      nxt_state = state_ff;
      nxt_bits = bits_ff;
      nxt_shift = shift_ff;
      nxt_hi = hi_ff;
      nxt_addr = addr_ff;
      nxt_wdat = wdat_ff;
      nxt_oe = oe_ff;
      nxt_rw = rw_ff;
      nxt_stb = 1'b0;
      if (ev.start) begin
         nxt_state = ST_DEV;
         nxt_bits = 4'h0;
         nxt_oe = 1'b0;
      end else if (ev.stop) begin
         nxt_state = ST_IDLE;
         nxt_oe = 1'b0;
      end else begin
         case (state_ff)
            ST_DEV, ST_ADRH, ST_ADRL, ST_WDAT: begin
               if (ev.scl_rise) begin
                  nxt_shift = {shift_ff[BYTE_W-2:0], sda_in};
                  nxt_bits = bits_ff + 4'h1;
               end else if (ev.scl_fall && bits_ff == BITS_FULL) begin
                  nxt_bits = 4'h0;
                  nxt_oe = 1'b1;
                  if (state_ff == ST_DEV) begin
                     nxt_rw = shift_ff[0];
                     nxt_state = ST_DACK;
                     if (!hdr_ok) begin
                        nxt_state = ST_IDLE;
                        nxt_oe = 1'b0;
                     end
                  end else if (state_ff == ST_ADRH) begin
                     nxt_hi = shift_ff;
                     nxt_state = ST_AACKH;
                  end else if (state_ff == ST_ADRL) begin
                     nxt_addr = {hi_ff, shift_ff};
                     nxt_state = ST_AACKL;
                  end else begin
                     nxt_wdat = shift_ff;
                     nxt_stb = 1'b1;
                     nxt_addr = addr_step(addr_ff, 1'b1);
                     nxt_state = ST_WACK;
                  end
               end
            end
            ST_DACK: begin
               if (ev.scl_fall) begin
                  nxt_bits = 4'h0;
                  if (rw_ff) begin
                     nxt_shift = mem_data_in;
                     nxt_oe = ~mem_data_in[BYTE_W-1];
                     nxt_state = ST_RDAT;
                  end else begin
                     nxt_oe = 1'b0;
                     nxt_state = ST_ADRH;
                  end
               end
            end
            ST_AACKH, ST_AACKL, ST_WACK: begin
               if (ev.scl_fall) begin
                  nxt_oe = 1'b0;
                  nxt_bits = 4'h0;
                  nxt_state = (state_ff == ST_AACKH) ? ST_ADRL : ST_WDAT;
               end
            end
            ST_RDAT: begin
               if (ev.scl_rise) begin
                  nxt_bits = bits_ff + 4'h1;
               end else if (ev.scl_fall) begin
                  if (bits_ff == BITS_FULL) begin
                     nxt_addr = addr_step(addr_ff, 1'b0);
                     nxt_bits = 4'h0;
                     nxt_oe = 1'b0;
                     nxt_state = ST_RACK;
                  end else begin
                     nxt_shift = {shift_ff[BYTE_W-2:0], 1'b0};
                     nxt_oe = ~shift_ff[BYTE_W-2];
                  end
               end
            end
            ST_RACK: begin
               if (ev.scl_rise) begin
                  if (sda_in) begin
                     nxt_state = ST_WAIT;
                  end else begin
                     nxt_bits = 4'h1;
                  end
               end else if (ev.scl_fall && bits_ff == 4'h1) begin
                  nxt_bits = 4'h0;
                  nxt_shift = mem_data_in;
                  nxt_oe = ~mem_data_in[BYTE_W-1];
                  nxt_state = ST_RDAT;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
               nxt_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_ff <= ST_IDLE;
         bits_ff <= 4'h0;
         shift_ff <= 8'h00;
         hi_ff <= 8'h00;
         addr_ff <= 16'h0000;
         wdat_ff <= 8'h00;
         oe_ff <= 1'b0;
         rw_ff <= 1'b0;
         stb_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         bits_ff <= nxt_bits;
         shift_ff <= nxt_shift;
         hi_ff <= nxt_hi;
         addr_ff <= nxt_addr;
         wdat_ff <= nxt_wdat;
         oe_ff <= nxt_oe;
         rw_ff <= nxt_rw;
         stb_ff <= nxt_stb;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = oe_ff;
   assign mem_addr_out = addr_ff;
   assign wr_data_out = wdat_ff;
   assign wr_strobe_out = stb_ff;

   // ==========================================
   // checks
   property p_start_dev;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ev.start |=> (state_ff == ST_DEV) && !oe_ff;
   endproperty
   a_start_dev: assert property (p_start_dev) else $error("start not decoded");

   property p_keep_addr;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (ev.start || ev.stop) |=> addr_ff == $past(addr_ff);
   endproperty
   a_keep_addr: assert property (p_keep_addr) else $error("counter reloaded");

   property p_ack_low;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (state_ff inside {ST_DACK, ST_AACKH, ST_AACKL, ST_WACK}) |-> oe_ff;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("ack not driven");

   property p_mismatch;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (state_ff == ST_DEV && ev.scl_fall && bits_ff == BITS_FULL && !hdr_ok
          && !ev.start && !ev.stop) |=> state_ff == ST_IDLE ##1 !oe_ff;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("mismatch acked");

   property p_rd_load;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (state_ff == ST_DACK && rw_ff && ev.scl_fall && !ev.start && !ev.stop)
            |=> state_ff == ST_RDAT && shift_ff == $past(mem_data_in);
   endproperty
   a_rd_load: assert property (p_rd_load) else $error("read byte not loaded");

   property p_msb;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (state_ff == ST_RDAT) |-> oe_ff == ~shift_ff[BYTE_W-1];
   endproperty
   a_msb: assert property (p_msb) else $error("wrong data bit driven");

   property p_rd_inc;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (state_ff == ST_RDAT && ev.scl_fall && bits_ff == BITS_FULL
          && !ev.start && !ev.stop)
            |=> addr_ff == $past(addr_ff) + 16'h0001 && state_ff == ST_RACK;
   endproperty
   a_rd_inc: assert property (p_rd_inc) else $error("read step wrong");

   property p_nack;
      @(posedge mclk_in) disable iff (!rst_n_in)
         (state_ff == ST_RACK && ev.scl_rise && sda_in && !ev.start && !ev.stop)
            |=> state_ff == ST_WAIT && !oe_ff;
   endproperty
   a_nack: assert property (p_nack) else $error("nack not honoured");

   property p_stop_idle;
      @(posedge mclk_in) disable iff (!rst_n_in)
         ev.stop && !ev.start |=> state_ff == ST_IDLE ##1 !oe_ff;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not to idle");

   c_located: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      state_ff == ST_AACKL ##[1:1000] state_ff == ST_RDAT);
   c_wrap: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      addr_ff == 16'hffff && state_ff == ST_RDAT ##[1:1000] addr_ff == 16'h0000);
   c_multi: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      state_ff == ST_RACK ##1 state_ff == ST_RACK [*1] ##[1:1000] state_ff == ST_RDAT);
endmodule // sre_read_engine

// [testbench/sre_bus_master.sv]
// two-wire bus master model: start, stop, byte out, byte in
// assumes the bench resolves sda as wired-and with a pull-up
`timescale 1ns/100ps
module sre_bus_master (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_drv_out
);
   localparam int HALF = 4;
   initial begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   task automatic wt();
      repeat (HALF) @(posedge clk_in);
   endtask
   // ====================================
   // bit and condition framing
   task automatic bit_io(input logic b, output logic s);
      @(posedge clk_in);
      sda_drv_out <= b;
      wt();
      scl_out <= 1'b1;
      wt();
      s = sda_in;
      scl_out <= 1'b0;
   endtask
   task automatic start();
      @(posedge clk_in);
      sda_drv_out <= 1'b1;
      wt();
      scl_out <= 1'b1;
      wt();
      sda_drv_out <= 1'b0;
      wt();
      scl_out <= 1'b0;
   endtask
   task automatic stop();
      @(posedge clk_in);
      sda_drv_out <= 1'b0;
      wt();
      scl_out <= 1'b1;
      wt();
      sda_drv_out <= 1'b1;
      wt();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~more, s);
   endtask
endmodule // sre_bus_master

// [testbench/tb_top.sv]
// self-checking bench for the read engine with a master model
// assumes array byte = pattern of address, straps high/low, swapped to low/high for the write test
`timescale 1ns/100ps
module tb_top;
   import sre_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic strap_hi = 1'b1;
   logic strap_lo = 1'b0;
   logic scl, sda_m, sda, sda_out, sda_oe_out, wr_strobe_out, ack;
   logic [ADDR_W-1:0] mem_addr_out;
   logic [BYTE_W-1:0] mem_data_in, wr_data_out, d;
   int n_errors = 0;
   int compares = 0;
   int n_strobes = 0;
   logic [BYTE_W-1:0] wr_seen;
   always #(MCLK_NS / 2.0) mclk_in = ~mclk_in;
   assign sda = sda_m & ~(sda_oe_out & ~sda_out);
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[15:8] + a[7:0] + 8'h5a;
   endfunction
   always_comb mem_data_in = pat(mem_addr_out);
   // write strobe monitor
   always @(posedge mclk_in) begin
      if (wr_strobe_out === 1'b1) begin
         n_strobes++;
         wr_seen = wr_data_out;
      end
   end
   sre_bus_master sre_bus_master_i (.clk_in(mclk_in), .sda_in(sda), .scl_out(scl),
      .sda_drv_out(sda_m));
   sre_read_engine sre_read_engine_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .strap_select_hi_in(strap_hi), .strap_select_lo_in(strap_lo),
      .mem_addr_out(mem_addr_out), .mem_data_in(mem_data_in),
      .wr_data_out(wr_data_out), .wr_strobe_out(wr_strobe_out));
   // ====================================
   // compares and closing
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t byte %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t addr %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   function automatic logic [7:0] hdr(input logic rw);
      return {DEV_PREFIX, strap_hi, strap_lo, rw};
   endfunction
   // ====================================
   // scenarios
   task automatic rd_open();
      sre_bus_master_i.start();
      sre_bus_master_i.wbyte(hdr(1'b1), ack);
      chk8({7'h00, ack}, 8'h01);
   endtask
   task automatic locate(input logic [15:0] a);
      sre_bus_master_i.start();
      sre_bus_master_i.wbyte(hdr(1'b0), ack);
      chk8({7'h00, ack}, 8'h01);
      sre_bus_master_i.wbyte(a[15:8], ack);
      chk8({7'h00, ack}, 8'h01);
      sre_bus_master_i.wbyte(a[7:0], ack);
      chk8({7'h00, ack}, 8'h01);
      rd_open();
   endtask
   task automatic t_reset_current();
      chk16(mem_addr_out, 16'h0000);
      rd_open();
      sre_bus_master_i.rbyte(1'b0, d);
      chk8(d, pat(16'h0000));
      sre_bus_master_i.stop();
      chk16(mem_addr_out, 16'h0001);
   endtask
   task automatic t_located_then_current();
      locate(16'h1234);
      sre_bus_master_i.rbyte(1'b0, d);
      chk8(d, pat(16'h1234));
      sre_bus_master_i.stop();
      rd_open();
      sre_bus_master_i.rbyte(1'b0, d);
      chk8(d, pat(16'h1235));
      sre_bus_master_i.stop();
   endtask
   task automatic t_wrap_sequential();
      locate(16'hffff);
      sre_bus_master_i.rbyte(1'b1, d);
      chk8(d, pat(16'hffff));
      sre_bus_master_i.rbyte(1'b1, d);
      chk8(d, pat(16'h0000));
      sre_bus_master_i.rbyte(1'b0, d);
      chk8(d, pat(16'h0001));
      repeat (6) @(posedge mclk_in);
      chk8({7'h00, sda_oe_out}, 8'h00);
      sre_bus_master_i.stop();
      chk8({7'h00, sda_oe_out}, 8'h00);
   endtask
   task automatic t_strap_miss_then_multi();
      sre_bus_master_i.start();
      sre_bus_master_i.wbyte({DEV_PREFIX, ~strap_hi, strap_lo, 1'b1}, ack);
      chk8({7'h00, ack}, 8'h00);
      sre_bus_master_i.stop();
      chk16(mem_addr_out, 16'h0002);
      rd_open();
      sre_bus_master_i.rbyte(1'b1, d);
      chk8(d, pat(16'h0002));
      sre_bus_master_i.rbyte(1'b0, d);
      chk8(d, pat(16'h0003));
      sre_bus_master_i.stop();
      rd_open();
      sre_bus_master_i.rbyte(1'b0, d);
      chk8(d, pat(16'h0004));
      sre_bus_master_i.stop();
   endtask
   task automatic t_write_page_wrap();
      strap_hi <= 1'b0;
      strap_lo <= 1'b1;
      sre_bus_master_i.start();
      sre_bus_master_i.wbyte({DEV_PREFIX, strap_hi, ~strap_lo, 1'b0}, ack);
      chk8({7'h00, ack}, 8'h00);
      sre_bus_master_i.stop();
      sre_bus_master_i.start();
      sre_bus_master_i.wbyte(hdr(1'b0), ack);
      chk8({7'h00, ack}, 8'h01);
      sre_bus_master_i.wbyte(8'h00, ack);
      chk8({7'h00, ack}, 8'h01);
      sre_bus_master_i.wbyte(8'h7f, ack);
      chk8({7'h00, ack}, 8'h01);
      sre_bus_master_i.wbyte(8'h3c, ack);
      chk8({7'h00, ack}, 8'h01);
      sre_bus_master_i.stop();
      chk16(n_strobes[15:0], 16'h0001);
      chk8(wr_seen, 8'h3c);
      chk8(wr_data_out, 8'h3c);
      chk16(mem_addr_out, 16'h0000);
      rd_open();
      sre_bus_master_i.rbyte(1'b0, d);
      chk8(d, pat(16'h0000));
      sre_bus_master_i.stop();
   endtask
   initial begin
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      t_reset_current();
      t_located_then_current();
      t_wrap_sequential();
      t_strap_miss_then_multi();
      t_write_page_wrap();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_errors++;
      tally_and_finish();
   end
endmodule // tb_top
